//--- hw/clu_decode.sv
`timescale 1ns/1ps
module clu_decode (
   input wire logic [31:0] instr,
   input wire logic mode64,
   input wire logic kernel,
   output clu_pkg::clu_kind_t kind,
   output logic rsvd
);
   // ==========================================
   // opcode decode
   // ==========================================
   wire logic [5:0] opc = instr[clu_pkg::OPC_HI:clu_pkg::OPC_LO];
   wire logic is_dbl = (opc == clu_pkg::OP_DBL_LEFT) || (opc == clu_pkg::OP_DBL_RIGHT);

   always_comb begin
      unique case (opc)
         clu_pkg::OP_DBL_RIGHT: kind = clu_pkg::CLU_K_DBL_RIGHT;
         clu_pkg::OP_DBL_LEFT: kind = clu_pkg::CLU_K_DBL_LEFT;
         clu_pkg::OP_HALF_S: kind = clu_pkg::CLU_K_HALF_S;
         clu_pkg::OP_HALF_U: kind = clu_pkg::CLU_K_HALF_U;
         clu_pkg::OP_UPPER_IMM: kind = clu_pkg::CLU_K_UPPER;
         clu_pkg::OP_WORD: kind = clu_pkg::CLU_K_WORD;
         clu_pkg::OP_WORD_LEFT: kind = clu_pkg::CLU_K_WORD_LEFT;
         default: kind = clu_pkg::CLU_K_NONE;
      endcase
   end

   // doubleword partial loads legal only in 64-bit or kernel mode
   assign rsvd = is_dbl && !mode64 && !kernel;
endmodule

//--- hw/clu_pkg.sv
package clu_pkg;

   // ==========================================
   // instruction fields
   // ==========================================
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int BASE_HI = 25;
   localparam int BASE_LO = 21;
   localparam int TGT_HI = 20;
   localparam int TGT_LO = 16;
   localparam int OFS_HI = 15;

   localparam logic [5:0] OP_DBL_LEFT = 6'h1A;
   localparam logic [5:0] OP_DBL_RIGHT = 6'h1B;
   localparam logic [5:0] OP_HALF_S = 6'h21;
   localparam logic [5:0] OP_WORD_LEFT = 6'h22;
   localparam logic [5:0] OP_WORD = 6'h23;
   localparam logic [5:0] OP_HALF_U = 6'h25;
   localparam logic [5:0] OP_UPPER_IMM = 6'h0F;

   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h3;
   localparam logic [2:0] SIZE_DWORD = 3'h7;
   localparam logic [63:0] RESET_DATA = 64'h0;

   // ==========================================
   // types
   // ==========================================
   typedef enum logic [2:0] {
      CLU_K_NONE,
      CLU_K_DBL_RIGHT,
      CLU_K_DBL_LEFT,
      CLU_K_HALF_S,
      CLU_K_HALF_U,
      CLU_K_UPPER,
      CLU_K_WORD,
      CLU_K_WORD_LEFT
   } clu_kind_t;

   typedef enum logic [2:0] {
      CLU_X_NONE,
      CLU_X_ADDR,
      CLU_X_RSVD,
      CLU_X_TLB_REFILL,
      CLU_X_TLB_INVALID,
      CLU_X_BUS
   } clu_exc_t;

   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [63:0] base_val;
      logic [63:0] tgt_val;
   } clu_issue_t;

   typedef struct packed {
      logic valid;
      logic [63:0] vaddr;
      logic [2:0] lane;
      logic [2:0] size;
   } clu_mreq_t;

   typedef struct packed {
      logic valid;
      logic [63:0] data;
      logic tlb_refill;
      logic tlb_invalid;
      logic bus_err;
   } clu_mrsp_t;

   typedef struct packed {
      logic valid;
      logic [4:0] tgt;
      logic [63:0] data;
      clu_exc_t exc;
   } clu_wb_t;

endpackage

//--- hw/clu_top.sv
`timescale 1ns/1ps
// Operation
// - doubleword-right, little-endian: offset 0 replaces all bytes, 7 only lowest.
// - doubleword-right in 32-bit user or supervisor mode raises reserved instruction.
// - address is sign-extended 16-bit offset plus base register.
// - signed halfword load sign-extends the halfword to register width.
// - unsigned halfword load zero-fills upper register bits.
// - halfword loads raise address error when address bit 0 set.
// - upper-immediate places immediate in bits 31..16, low half cleared.
// - in 64-bit mode upper-immediate, word and word-left sign-extend from bit 31.
// - aligned word load writes the addressed 32-bit word.
// - word load raises address error if address bits 1 or 0 nonzero.
// - word-left pairs with word-right; fills upper register part.
// - word-left reads only the containing word, one to four bytes.
// - word-left starting byte goes to top; low register bytes kept.
// - target written by preceding load forwarded to next partial load.
// - word-left never raises an alignment address error.
// - halfword and word loads report TLB and bus exceptions.
// - word-left decoded from opcode bits 31..26 with base, target, offset.
// - doubleword partial loads trap outside 64-bit or kernel mode.
module clu_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input clu_pkg::clu_issue_t issue,
   input wire logic mode64,
   input wire logic kernel,
   input wire logic memory_byte_order_flag,
   input wire logic processor_byte_order_flag,
   input wire logic byte_order_swap_flag,
   output logic issue_ready,
   output clu_pkg::clu_mreq_t mreq,
   input clu_pkg::clu_mrsp_t mrsp,
   output clu_pkg::clu_wb_t wb
);
   typedef enum logic [1:0] {CLU_IDLE, CLU_WAIT} clu_state_t;

   function automatic logic [63:0] clu_sx32(input logic [31:0] v, input logic m64);
      clu_sx32 = m64 ? {{32{v[31]}}, v} : {32'h0, v};
   endfunction

   // ==========================================
   // decode and address
   // ==========================================
   clu_pkg::clu_kind_t kind;
   logic rsvd;
   clu_decode u_dec (
      .instr(issue.instr),
      .mode64(mode64),
      .kernel(kernel),
      .kind(kind),
      .rsvd(rsvd)
   );

   clu_state_t state_r;
   clu_state_t state_nxt;
   clu_pkg::clu_kind_t kind_r;
   logic [4:0] tgt_r;
   logic [63:0] tgt_val_r;
   logic [2:0] lane_r;
   logic [2:0] vlo_r;
   logic m64_r;
   clu_pkg::clu_wb_t wb_r;
   clu_pkg::clu_wb_t wb_nxt;
   clu_pkg::clu_mreq_t mreq_r;
   clu_pkg::clu_mreq_t mreq_nxt;

   wire logic [4:0] tgt = issue.instr[clu_pkg::TGT_HI:clu_pkg::TGT_LO];
   wire logic [15:0] ofs = issue.instr[clu_pkg::OFS_HI:0];
   wire logic [63:0] vaddr = {{48{ofs[15]}}, ofs} + issue.base_val;
   wire logic [2:0] vlo = vaddr[2:0];
   // forward a just-written target so partial loads merge the new value
   wire logic fwd_hit = wb_r.valid && (wb_r.exc == clu_pkg::CLU_X_NONE) && (wb_r.tgt == tgt);
   wire logic [63:0] tgt_cur = fwd_hit ? wb_r.data : issue.tgt_val;
   wire logic be_cpu = processor_byte_order_flag ^ byte_order_swap_flag;
   wire logic half_mis = vlo[0];
   wire logic word_mis = |vlo[1:0];
   wire logic is_half = (kind == clu_pkg::CLU_K_HALF_S) || (kind == clu_pkg::CLU_K_HALF_U);
   wire logic is_word = kind == clu_pkg::CLU_K_WORD;
   wire logic is_dbl = (kind == clu_pkg::CLU_K_DBL_RIGHT) || (kind == clu_pkg::CLU_K_DBL_LEFT);
   wire logic align_err = (is_half && half_mis) || (is_word && word_mis);
   // lane of the data within the doubleword after endian adjust
   wire logic [2:0] lane_h = vlo ^ {be_cpu, be_cpu, 1'b0};
   wire logic [2:0] lane_w = vlo ^ {be_cpu, 2'h0};
   wire logic accept = issue.valid && (state_r == CLU_IDLE);
   wire logic needs_mem = (kind != clu_pkg::CLU_K_UPPER) && (kind != clu_pkg::CLU_K_NONE);

   assign issue_ready = state_r == CLU_IDLE;

   // ==========================================
   // merge of returned data
   // ==========================================
   wire logic [63:0] mdat = mrsp.data;
   wire logic [5:0] sh8 = {lane_r, 3'h0};
   wire logic [63:0] dright_mask = {64{1'b1}} >> sh8;
   wire logic [63:0] dright_keep = tgt_val_r & ~dright_mask;
   wire logic [63:0] dright_data = ((mdat >> sh8) & dright_mask) | dright_keep;
   wire logic [5:0] dleft_sh = {~lane_r, 3'h0};
   wire logic [63:0] dleft_mask = {64{1'b1}} << dleft_sh;
   wire logic [63:0] dleft_data = (mdat << dleft_sh) | (tgt_val_r & ~dleft_mask);
   wire logic [15:0] half = mdat[{lane_r[2:1], 4'h0} +: 16];
   wire logic [31:0] word = mdat[{lane_r[2], 5'h0} +: 32];
   // word-left: byte index within word, starting byte goes to bit 31
   wire logic [1:0] wbyte = vlo_r[1:0] ^ {2{be_cpu}};
   wire logic [31:0] mword = mdat[{vlo_r[2] ^ be_cpu, 5'h0} +: 32];
   wire logic [4:0] lsh = {~wbyte, 3'h0};
   wire logic [31:0] wleft_mask = 32'hFFFFFFFF << lsh;
   wire logic [31:0] wleft_keep = tgt_val_r[31:0] & ~wleft_mask;
   wire logic [31:0] wleft_word = (mword << lsh) | wleft_keep;

   always_comb begin
      unique case (kind_r)
         clu_pkg::CLU_K_DBL_RIGHT: wb_nxt.data = dright_data;
         clu_pkg::CLU_K_DBL_LEFT: wb_nxt.data = dleft_data;
         clu_pkg::CLU_K_HALF_S: wb_nxt.data = {{48{half[15]}}, half};
         clu_pkg::CLU_K_HALF_U: wb_nxt.data = {48'h0, half};
         clu_pkg::CLU_K_WORD_LEFT: wb_nxt.data = clu_sx32(wleft_word, m64_r);
         default: wb_nxt.data = clu_sx32(word, m64_r);
      endcase
      wb_nxt.valid = 1'b0;
      wb_nxt.tgt = tgt_r;
      wb_nxt.exc = clu_pkg::CLU_X_NONE;
      mreq_nxt = '0;
      state_nxt = state_r;
      if (state_r == CLU_WAIT && mrsp.valid) begin
         wb_nxt.valid = 1'b1;
         state_nxt = CLU_IDLE;
         if (mrsp.tlb_refill) begin
            wb_nxt.exc = clu_pkg::CLU_X_TLB_REFILL;
         end else if (mrsp.tlb_invalid) begin
            wb_nxt.exc = clu_pkg::CLU_X_TLB_INVALID;
         end else if (mrsp.bus_err) begin
            wb_nxt.exc = clu_pkg::CLU_X_BUS;
         end
      end else if (accept && kind != clu_pkg::CLU_K_NONE) begin
         wb_nxt.tgt = tgt;
         if (rsvd) begin
            wb_nxt.valid = 1'b1;
            wb_nxt.exc = clu_pkg::CLU_X_RSVD;
         end else if (align_err) begin
            wb_nxt.valid = 1'b1;
            wb_nxt.exc = clu_pkg::CLU_X_ADDR;
         end else if (!needs_mem) begin
            wb_nxt.valid = 1'b1;
            wb_nxt.data = clu_sx32({ofs, 16'h0}, mode64);
         end else begin
            state_nxt = CLU_WAIT;
            mreq_nxt.valid = 1'b1;
            mreq_nxt.vaddr = vaddr;
            mreq_nxt.lane = is_half ? lane_h : lane_w;
            mreq_nxt.size = is_half ? {1'b0, clu_pkg::SIZE_HALF} : {1'b0, clu_pkg::SIZE_WORD};
            if (is_dbl) begin
               mreq_nxt.lane = vlo ^ {3{be_cpu}};
               mreq_nxt.size = clu_pkg::SIZE_DWORD;
            end
         end
      end
   end

   // ==========================================
   // state
   // ==========================================
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_r <= CLU_IDLE;
         wb_r <= '0;
         mreq_r <= '0;
         kind_r <= clu_pkg::CLU_K_NONE;
         tgt_r <= 5'h0;
         tgt_val_r <= clu_pkg::RESET_DATA;
         lane_r <= 3'h0;
         vlo_r <= 3'h0;
         m64_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wb_r <= wb_nxt;
         mreq_r <= mreq_nxt;
         if (accept) begin
            kind_r <= kind;
            tgt_r <= tgt;
            tgt_val_r <= tgt_cur;
            lane_r <= is_dbl ? vlo ^ {3{be_cpu}} : (is_half ? lane_h : lane_w);
            vlo_r <= vlo;
            m64_r <= mode64;
         end
      end
   end

   assign wb = wb_r;
   assign mreq = mreq_r;

   // ==========================================
   // checks
   // ==========================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   rsvd_trap_a: assert property (
      accept && rsvd |=> wb.valid && wb.exc == clu_pkg::CLU_X_RSVD && !mreq.valid)
      else $error("reserved trap missing");
   half_align_a: assert property (
      accept && is_half && half_mis && !rsvd |=> wb.exc == clu_pkg::CLU_X_ADDR)
      else $error("halfword align error missing");
   word_align_a: assert property (
      accept && is_word && word_mis |=> wb.valid && wb.exc == clu_pkg::CLU_X_ADDR)
      else $error("word align error missing");
   wleft_noalign_a: assert property (
      accept && kind == clu_pkg::CLU_K_WORD_LEFT |=> wb.exc != clu_pkg::CLU_X_ADDR)
      else $error("word-left alignment error");
   upper_imm_a: assert property (
      accept && kind == clu_pkg::CLU_K_UPPER |=> wb.valid && wb.exc == clu_pkg::CLU_X_NONE
         && wb.data[15:0] == 16'h0 && wb.data[31:16] == $past(ofs))
      else $error("upper immediate wrong");
   upper_nomem_a: assert property (
      accept && kind == clu_pkg::CLU_K_UPPER |=> !mreq.valid)
      else $error("upper immediate issued a read");
   addr_form_a: assert property (
      mreq.valid |-> mreq.vaddr == $past(vaddr))
      else $error("address formation wrong");
   sext_a: assert property (
      wb.valid && m64_r && wb.exc == clu_pkg::CLU_X_NONE && $past(state_r) == CLU_WAIT
         && (kind_r == clu_pkg::CLU_K_WORD || kind_r == clu_pkg::CLU_K_WORD_LEFT)
         |-> wb.data[63:32] == {32{wb.data[31]}})
      else $error("sign extension wrong");
   half_sext_a: assert property (
      wb.valid && wb.exc == clu_pkg::CLU_X_NONE && $past(state_r) == CLU_WAIT
         && kind_r == clu_pkg::CLU_K_HALF_S |-> wb.data[63:16] == {48{wb.data[15]}})
      else $error("signed halfword not sign-extended");
   half_zero_a: assert property (
      wb.valid && kind_r == clu_pkg::CLU_K_HALF_U && $past(state_r) == CLU_WAIT
         |-> wb.data[63:16] == 48'h0)
      else $error("unsigned halfword not zero-filled");
   dright_full_a: assert property (
      state_r == CLU_WAIT && mrsp.valid && kind_r == clu_pkg::CLU_K_DBL_RIGHT && lane_r == 3'h0
         |=> wb.exc != clu_pkg::CLU_X_NONE || wb.data == $past(mdat))
      else $error("doubleword-right merge wrong");

   word_cov_c: cover property (accept && is_word ##[1:20] wb.valid);
   wleft_cov_c: cover property (accept && kind == clu_pkg::CLU_K_WORD_LEFT ##[1:20] wb.valid);
   fwd_cov_c: cover property (accept && fwd_hit);
   dleft_cov_c: cover property (accept && kind == clu_pkg::CLU_K_DBL_LEFT && !rsvd);
endmodule

//--- testbench/clu_mem_model.sv
`timescale 1ns/1ps
module clu_mem_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input clu_pkg::clu_mreq_t mreq,
   input wire logic [3:0] lat,
   input wire logic [2:0] err,
   output clu_pkg::clu_mrsp_t mrsp
);
   // ==========================================
   // memory side: one answer per request
   // ==========================================
   logic [63:0] addr_r;
   logic [3:0] cnt_r;
   logic busy_r;
   wire logic go = (mreq.valid === 1'h1 && lat == 4'h0) || (busy_r && cnt_r == 4'h0);
   wire logic [63:0] a = busy_r ? addr_r : mreq.vaddr;

   always @(posedge ref_clk) begin
      mrsp.valid <= 1'h0;
      // data is not held once the answer has passed
      mrsp.data <= ~mrsp.data;
      {mrsp.tlb_refill, mrsp.tlb_invalid, mrsp.bus_err} <= 3'h0;
      if (!rst_b) begin
         busy_r <= 1'h0;
         mrsp.data <= 64'h5A5A_A5A5_5A5A_A5A5;
      end else if (go) begin
         busy_r <= 1'h0;
         mrsp.valid <= 1'h1;
         mrsp.data <= {8{a[10:3]}} ^ 64'h8F7E_6D5C_4B3A_2918;
         {mrsp.tlb_refill, mrsp.tlb_invalid, mrsp.bus_err} <= err;
      end else if (mreq.valid === 1'h1) begin
         busy_r <= 1'h1;
         addr_r <= mreq.vaddr;
         cnt_r <= lat - 4'h1;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule

//--- testbench/clu_top_bench.sv
`timescale 1ns/1ps
module clu_top_bench;
   // ==========================================
   // signals and instances
   // ==========================================
   localparam logic [63:0] M = 64'h8F7E_6D5C_4B3A_2918;
   localparam logic [63:0] T = 64'h0123_4567_89AB_CDEF;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   clu_pkg::clu_issue_t issue = '0;
   logic mode64 = 1'h1;
   logic kernel = 1'h0;
   logic be_cpu = 1'h0;
   logic swap = 1'h0;
   logic issue_ready;
   clu_pkg::clu_mreq_t mreq;
   clu_pkg::clu_mrsp_t mrsp;
   clu_pkg::clu_wb_t wb;
   logic [3:0] lat = 4'h0;
   logic [2:0] err = 3'h0;
   logic [63:0] seen_va;
   logic [2:0] seen_lane;
   logic [2:0] seen_size;
   logic seen_rdy;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_req = 0;

   always #12.5 ref_clk = ~ref_clk;

   clu_top i_clu_top (.ref_clk(ref_clk), .rst_b(rst_b), .issue(issue), .mode64(mode64),
      .kernel(kernel), .memory_byte_order_flag(1'h0), .processor_byte_order_flag(be_cpu),
      .byte_order_swap_flag(swap), .issue_ready(issue_ready), .mreq(mreq), .mrsp(mrsp),
      .wb(wb));
   clu_mem_model i_clu_mem_model (.ref_clk(ref_clk), .rst_b(rst_b), .mreq(mreq), .lat(lat),
      .err(err), .mrsp(mrsp));

   always @(posedge ref_clk) begin
      if (mreq.valid === 1'h1) begin
         seen_va <= mreq.vaddr;
         seen_lane <= mreq.lane;
         seen_size <= mreq.size;
         seen_rdy <= issue_ready;
         n_req <= n_req + 1;
      end
   end

   // ==========================================
   // helpers
   // ==========================================
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [63:0] sx(input logic [31:0] w);
      return {{32{w[31]}}, w};
   endfunction

   // base register holds 0x2000; returns at the falling edge showing write-back
   task automatic run(input logic [5:0] op, input logic [15:0] ofs, input logic [63:0] tgt);
      int i;
      issue = {1'h1, op, 5'h3, 5'h7, ofs, 64'h2000, tgt};
      @(posedge ref_clk);
      @(negedge ref_clk);
      issue.valid = 1'h0;
      for (i = 0; i < 40 && wb.valid !== 1'h1; i++) begin
         @(negedge ref_clk);
      end
      if (i == 40) begin
         n_mismatch++;
         conclude();
      end
   endtask

   task automatic ck(input logic [63:0] d);
      check("wb exc", 64'(wb.exc), 64'(clu_pkg::CLU_X_NONE));
      check("wb tgt", 64'(wb.tgt), 64'h7);
      check("wb data", wb.data, d);
   endtask

   task automatic ckx(input clu_pkg::clu_exc_t x);
      check("wb exc", 64'(wb.exc), 64'(x));
   endtask

   // ==========================================
   // scenarios
   // ==========================================
   task automatic t_upper();
      int k;
      k = n_req;
      run(clu_pkg::OP_UPPER_IMM, 16'h8765, 64'h0);
      ck(64'hFFFF_FFFF_8765_0000);
      check("no read", 64'(n_req), 64'(k));
      mode64 = 1'h0;
      run(clu_pkg::OP_UPPER_IMM, 16'h8765, 64'h0);
      ck(64'h8765_0000);
      mode64 = 1'h1;
   endtask

   task automatic t_word();
      run(clu_pkg::OP_WORD, 16'hFFF8, 64'h0);
      check("vaddr", seen_va, 64'h1FF8);
      check("req size", 64'(seen_size), 64'(clu_pkg::SIZE_WORD));
      check("busy refuses", 64'(seen_rdy), 64'h0);
      check("idle ready", 64'(issue_ready), 64'h1);
      ck(64'hFFFF_FFFF_B4C5_D6E7);
      run(clu_pkg::OP_WORD, 16'h4, 64'h0);
      ck(sx(M[63:32]));
      check("req lane", 64'(seen_lane), 64'h4);
      be_cpu = 1'h1;
      run(clu_pkg::OP_WORD, 16'h0, 64'h0);
      ck(sx(M[63:32]));
      check("req lane", 64'(seen_lane), 64'h4);
      swap = 1'h1;
      run(clu_pkg::OP_WORD, 16'h0, 64'h0);
      ck(sx(M[31:0]));
      check("req lane", 64'(seen_lane), 64'h0);
      be_cpu = 1'h0;
      swap = 1'h0;
      for (int i = 1; i < 4; i++) begin
         run(clu_pkg::OP_WORD, 16'(i), 64'h0);
         ckx(clu_pkg::CLU_X_ADDR);
      end
   endtask

   task automatic t_half();
      run(clu_pkg::OP_HALF_S, 16'h6, 64'h0);
      ck({48'hFFFF_FFFF_FFFF, M[63:48]});
      check("req lane", 64'(seen_lane), 64'h6);
      check("req size", 64'(seen_size), 64'(clu_pkg::SIZE_HALF));
      run(clu_pkg::OP_HALF_U, 16'h6, 64'h0);
      ck({48'h0, M[63:48]});
      run(clu_pkg::OP_HALF_S, 16'h1, 64'h0);
      ckx(clu_pkg::CLU_X_ADDR);
      run(clu_pkg::OP_HALF_U, 16'h7, 64'h0);
      ckx(clu_pkg::CLU_X_ADDR);
   endtask

   // an idle cycle before each partial load whose data is checked keeps the last result from being forwarded
   task automatic t_partial();
      logic [63:0] mw;
      logic [31:0] t;
      int sh;
      for (int b = 0; b < 8; b++) begin
         @(negedge ref_clk);
         run(clu_pkg::OP_DBL_RIGHT, 16'(b), T);
         ck((T & ~(64'hFFFF_FFFF_FFFF_FFFF >> (8 * b))) | (M >> (8 * b)));
         check("req size", 64'(seen_size), 64'(clu_pkg::SIZE_DWORD));
      end
      for (int b = 0; b < 8; b++) begin
         mw = M >> (32 * (b / 4));
         sh = 24 - 8 * (b % 4);
         t = (mw[31:0] << sh) | (T[31:0] & ((32'h1 << sh) - 32'h1));
         @(negedge ref_clk);
         run(clu_pkg::OP_WORD_LEFT, 16'(b), T);
         ck(sx(t));
      end
      @(negedge ref_clk);
      run(clu_pkg::OP_DBL_LEFT, 16'h2, T);
      ck(64'h3A29_1867_89AB_CDEF);
      mode64 = 1'h0;
      run(clu_pkg::OP_DBL_RIGHT, 16'h0, T);
      ckx(clu_pkg::CLU_X_RSVD);
      run(clu_pkg::OP_DBL_LEFT, 16'h0, T);
      ckx(clu_pkg::CLU_X_RSVD);
      kernel = 1'h1;
      run(clu_pkg::OP_DBL_RIGHT, 16'h0, T);
      ckx(clu_pkg::CLU_X_NONE);
      kernel = 1'h0;
      mode64 = 1'h1;
   endtask

   task automatic t_fault();
      lat = 4'h5;
      for (int k = 0; k < 3; k++) begin
         err = 3'h4 >> k;
         run(clu_pkg::OP_WORD, 16'h0, 64'h0);
         ckx(clu_pkg::clu_exc_t'(3 + k));
      end
      err = 3'h0;
      run(clu_pkg::OP_HALF_S, 16'h0, 64'h0);
      ck({48'h0, M[15:0]});
      lat = 4'h0;
      run(clu_pkg::OP_WORD, 16'h4, 64'h0);
      run(clu_pkg::OP_DBL_RIGHT, 16'h4, 64'h0);
      ck({32'hFFFF_FFFF, M[63:32]});
   endtask

   initial begin
      repeat (10) @(negedge ref_clk);
      rst_b = 1'h1;
      t_upper();
      t_word();
      t_half();
      t_partial();
      t_fault();
      conclude();
   end
endmodule
